// *** verilog/led_current_scaling.v ***
// per-channel current trim and per-group brightness scaling for 24 sinks
// in three colour groups, with an axi4-lite register slave.
// assumes clk at 10 MHz, blankingInputN from a pin, bus on clk.
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "led_current_scaling_defines.vh"

module led_current_scaling #(
	parameter CHANNELS = `CHANNELS,
	parameter LEVEL_W = `LEVEL_W,
	parameter COUNT_W = `COUNT_W
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// axi4-lite write address
	input wire awvalid,
	output wire awready,
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	// axi4-lite write data
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// axi4-lite write response
	output wire bvalid,
	input wire bready,
	output wire [1:0] bresp,
	// axi4-lite read address
	input wire arvalid,
	output wire arready,
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	// axi4-lite read data
	output wire rvalid,
	input wire rready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	// blanking pin
	input wire blankingInputN,
	// sink stage
	output wire [CHANNELS-1:0] sinkEnable,
	output wire [CHANNELS*LEVEL_W-1:0] levelCodes
);

	// level code = (offset + 2*trim) * brightness * full / (3*127*255)
	function [15:0] calcLevel;
		input [6:0] trim;
		input [7:0] bright;
		input highRange;
		reg [39:0] num;
		reg [39:0] prod;
		begin
			// low range: twice the trim over 381; high range adds 127
			num = {32'h0, trim, 1'b0};
			if (highRange) begin
				num = num + `HIGH_OFFSET;
			end
			// 40 bits hold the worst product, 381 * 255 * 65535
			prod = num * {32'h0, bright};
			prod = prod * `LEVEL_MAX;
			prod = prod / `SCALE_DEN;
			calcLevel = prod[15:0];
		end
	endfunction

	// aligned and inside the map
	function isWord;
		input [7:0] addr;
		begin
			isWord = (addr[1:0] == 2'h0) && (addr <= `LAST_ADDR);
		end
	endfunction

	// register file
	reg [6:0] trim_r [0:CHANNELS-1];
	reg [7:0] bright_r [0:`GROUPS-1];
	reg [2:0] range_r;

	// blanking path and group counters
	reg [COUNT_W-1:0] count_r [0:`GROUPS-1];
	reg blankMeta_r;
	reg blankSync_r;
	reg blankPrev_r;

	// sink stage outputs and refresh pointer
	reg [CHANNELS-1:0] sinkEnable_r;
	reg [CHANNELS*LEVEL_W-1:0] levelFlat_r;
	reg [4:0] chan_r;

	// bus slave state
	reg awHave_r;
	reg wHave_r;
	reg [7:0] awAddr_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	reg bValid_r;
	reg [1:0] bResp_r;
	reg rValid_r;
	reg [31:0] rData_r;
	reg [1:0] rResp_r;

	// combinational helpers and loop indices
	reg [31:0] readVal;
	reg [1:0] chanGroup;
	integer i;
	integer g;

	wire doWrite = awHave_r && wHave_r && !bValid_r;
	wire [7:0] wIdx = awAddr_r >> 2;
	wire [7:0] rIdx = araddr >> 2;

	// ready outputs are combinational, the rest come from flops
	assign awready = !awHave_r && !bValid_r;
	assign wready = !wHave_r && !bValid_r;
	assign bvalid = bValid_r;
	assign bresp = bResp_r;
	assign arready = !rValid_r;
	assign rvalid = rValid_r;
	assign rdata = rData_r;
	assign rresp = rResp_r;
	assign sinkEnable = sinkEnable_r;
	assign levelCodes = levelFlat_r;

	// read decode
	// unmapped or unaligned reads are zeroed by the bus slave
	always @* begin
		readVal = 32'h0;
		if (araddr < `BRIGHT_BASE) begin
			readVal = {25'h0, trim_r[rIdx[4:0]]};
		end else if (araddr < `RANGE_ADDR) begin
			readVal = {24'h0, bright_r[rIdx[1:0] - 2'h0]};
			case (araddr)
			8'h60: readVal = {24'h0, bright_r[0]};
			8'h64: readVal = {24'h0, bright_r[1]};
			default: readVal = {24'h0, bright_r[2]};
			endcase
		end else if (araddr == `RANGE_ADDR) begin
			readVal = {29'h0, range_r};
		end else if (araddr == `STATUS_ADDR) begin
			readVal = {31'h0, blankSync_r};
		end else begin
			case (araddr)
			8'h74: readVal = {20'h0, count_r[0]};
			8'h78: readVal = {20'h0, count_r[1]};
			default: readVal = {20'h0, count_r[2]};
			endcase
		end
	end

	// bus slave
	always @(posedge clk) begin
		if (!nrst) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= `RESP_OKAY;
			rValid_r <= 1'b0;
			rData_r <= 32'h0;
			rResp_r <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end
			// answer only once both halves are held
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				bValid_r <= 1'b1;
				if (isWord(awAddr_r) && awAddr_r <= `RANGE_ADDR) begin
					bResp_r <= `RESP_OKAY;
				end else begin
					bResp_r <= `RESP_SLVERR;
				end
			end else if (bValid_r && bready) begin
				bValid_r <= 1'b0;
			end
			// a pending read answer refuses the next address
			if (arvalid && arready) begin
				rValid_r <= 1'b1;
				if (isWord(araddr)) begin
					rData_r <= readVal;
					rResp_r <= `RESP_OKAY;
				end else begin
					rData_r <= 32'h0;
					rResp_r <= `RESP_SLVERR;
				end
			end else if (rValid_r && rready) begin
				rValid_r <= 1'b0;
			end
		end
	end

	// trim, brightness and range storage, low byte lane only
	// bits above each field are dropped and read back as zero
	// status and counters are read only
	always @(posedge clk) begin
		if (!nrst) begin
			for (i = 0; i < CHANNELS; i = i + 1) begin
				trim_r[i] <= `TRIM_RST;
			end
			for (i = 0; i < `GROUPS; i = i + 1) begin
				bright_r[i] <= `BRIGHT_RST;
			end
			range_r <= `RANGE_RST;
		end else if (doWrite && wStrb_r[0] && isWord(awAddr_r)) begin
			if (awAddr_r < `BRIGHT_BASE) begin
				trim_r[wIdx[4:0]] <= wData_r[6:0];
			end else if (awAddr_r == `BRIGHT_BASE) begin
				bright_r[0] <= wData_r[7:0];
			end else if (awAddr_r == 8'h64) begin
				bright_r[1] <= wData_r[7:0];
			end else if (awAddr_r == 8'h68) begin
				bright_r[2] <= wData_r[7:0];
			end else if (awAddr_r == `RANGE_ADDR) begin
				range_r <= wData_r[2:0];
			end
		end
	end

	// blanking pin synchroniser and group counters
	always @(posedge clk) begin
		if (!nrst) begin
			blankMeta_r <= 1'b0;
			blankSync_r <= 1'b0;
			blankPrev_r <= 1'b0;
			sinkEnable_r <= {CHANNELS{1'b0}};
			for (g = 0; g < `GROUPS; g = g + 1) begin
				count_r[g] <= {COUNT_W{1'b0}};
			end
		end else begin
			// only the second flop reads the first
			blankMeta_r <= blankingInputN;
			blankSync_r <= blankMeta_r;
			blankPrev_r <= blankSync_r;
			// sinks off whenever blanking is low
			sinkEnable_r <= {CHANNELS{blankSync_r}};
			// counters restart on either change of the synced level
			for (g = 0; g < `GROUPS; g = g + 1) begin
				if (!blankSync_r || blankPrev_r != blankSync_r) begin
					count_r[g] <= {COUNT_W{1'b0}};
				end else begin
					count_r[g] <= count_r[g] + 1'b1;
				end
			end
		end
	end

	// level codes refreshed one channel per cycle, round robin
	// one shared divider serves all outputs; a write reaches its
	// level code within 25 cycles
	always @* begin
		// group of the channel being refreshed
		chanGroup = 2'h2;
		if (chan_r < `GROUP_SIZE) begin
			chanGroup = 2'h0;
		end else if (chan_r < 2 * `GROUP_SIZE) begin
			chanGroup = 2'h1;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			chan_r <= 5'h00;
			levelFlat_r <= {CHANNELS*LEVEL_W{1'b0}};
		end else begin
			levelFlat_r[chan_r*LEVEL_W +: LEVEL_W] <= calcLevel(
				trim_r[chan_r], bright_r[chanGroup],
				range_r[chanGroup]);
			if (chan_r == CHANNELS - 1) begin
				chan_r <= 5'h00;
			end else begin
				chan_r <= chan_r + 5'h01;
			end
		end
	end

endmodule // led_current_scaling

// *** inc/led_current_scaling_defines.vh ***
// constants for the led current scaling block: register map, field
// widths, reset values and scaling figures.
// assumes nothing beyond plain verilog-2005 inclusion.
`ifndef LED_CURRENT_SCALING_DEFINES_VH
`define LED_CURRENT_SCALING_DEFINES_VH

// register byte addresses
`define TRIM_BASE 8'h00
`define BRIGHT_BASE 8'h60
`define RANGE_ADDR 8'h6C
`define STATUS_ADDR 8'h70
`define COUNT_BASE 8'h74
`define LAST_ADDR 8'h7C

// field widths and counts
`define CHANNELS 24
`define GROUPS 3
`define GROUP_SIZE 8
`define TRIM_W 7
`define BRIGHT_W 8
`define LEVEL_W 16
`define COUNT_W 12

// reset values
`define TRIM_RST 7'h00
`define BRIGHT_RST 8'h00
`define RANGE_RST 3'h0

// scaling figures: trim max code, brightness max code, level full scale
`define TRIM_MAX 127
`define BRIGHT_MAX 255
`define LEVEL_MAX 65535
// high range offset in half trim steps (added to 2*trim): one third of full span = 127/381
`define HIGH_OFFSET 127
// denominator: 3 * 127 * 255
`define SCALE_DEN 97155

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verification/led_current_scaling_sva.sv ***
// assertions on the led_current_scaling ports
// assumes one clock and the bind below
`timescale 1ns/1ps
`include "led_current_scaling_defines.vh"
module led_current_scaling_sva #(parameter CHANNELS = 24) (
	input wire clk, nrst, blankingInputN,
	input wire awvalid, awready, wvalid, wready, bvalid, bready,
	input wire arvalid, arready, rvalid, rready,
	input wire [7:0] araddr,
	input wire [1:0] bresp, rresp,
	input wire [31:0] rdata,
	input wire [CHANNELS-1:0] sinkEnable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire wTake = awvalid && awready && wvalid && wready;
	wire rTake = arvalid && arready;
	property p_blank; (!blankingInputN)[*3] |=> sinkEnable == 0; endproperty
	a_blank: assert property (p_blank)
		else $error("sinks on while blanked");
	property p_cnt;
		(!blankingInputN)[*4] ##0 rTake && araddr >= `COUNT_BASE |=> rdata == 0;
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("counter not held at zero");
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
	property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped");
	property p_arrdy; rvalid |-> !arready; endproperty
	a_arrdy: assert property (p_arrdy)
		else $error("read taken while busy");
	property p_rlat; rTake |=> rvalid; endproperty
	a_rlat: assert property (p_rlat)
		else $error("read answer late");
	property p_wlat; wTake |-> ##[1:2] bvalid; endproperty
	a_wlat: assert property (p_wlat)
		else $error("write answer late");
	property p_bad;
		rTake && araddr > `LAST_ADDR |=> rresp == `RESP_SLVERR && rdata == 0;
	endproperty
	a_bad: assert property (p_bad)
		else $error("unmapped read accepted");
endmodule // led_current_scaling_sva
bind led_current_scaling led_current_scaling_sva #(.CHANNELS(CHANNELS)) chk (
	.clk(clk), .nrst(nrst), .blankingInputN(blankingInputN),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
	.rvalid(rvalid), .rready(rready), .araddr(araddr), .bresp(bresp),
	.rresp(rresp), .rdata(rdata), .sinkEnable(sinkEnable));

// *** verification/sink_stage_model.sv ***
// sink stage model: current code of one chosen output
// assumes 16-bit level codes packed per channel
`timescale 1ns/1ps
module sink_stage_model (
	input wire [23:0] sinkEnable,
	input wire [383:0] levelCodes,
	input wire [4:0] chSel,
	output wire [15:0] sinkCurrent
);
	// an output that is off sinks nothing
	assign sinkCurrent = sinkEnable[chSel] ? levelCodes[chSel*16 +: 16] : 16'h0;
endmodule // sink_stage_model

// *** verification/led_current_scaling_bench.sv ***
// bench for led_current_scaling: bus tasks and level checks
// assumes the sink model and the bound checker
`timescale 1ns/1ps
`include "led_current_scaling_defines.vh"
module led_current_scaling_bench;
	reg clk, nrst, awvalid, wvalid, bready, arvalid, rready, blankingInputN;
	reg [7:0] awaddr, araddr, i;
	reg [31:0] wdata;
	reg [3:0] wstrb, strbSel;
	reg [4:0] chSel;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [23:0] sinkEnable;
	wire [383:0] levelCodes;
	wire [15:0] sinkCurrent;
	integer n_mismatch, checked;
	led_current_scaling dut (.clk(clk), .nrst(nrst), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .blankingInputN(blankingInputN),
		.sinkEnable(sinkEnable), .levelCodes(levelCodes));
	sink_stage_model sink (.sinkEnable(sinkEnable), .levelCodes(levelCodes),
		.chSel(chSel), .sinkCurrent(sinkCurrent));
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	task close_out;
	begin
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task cmp(input [47:0] nm, input [31:0] e, input [31:0] g);
	begin
		checked = checked + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
	begin
		awaddr <= a;
		wdata <= d;
		wstrb <= strbSel;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
		cmp("bresp", er, bresp);
		@(posedge clk);
	end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [1:0] er);
	begin
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
		cmp("rdata", e, rdata);
		cmp("rresp", er, rresp);
		@(posedge clk);
	end
	endtask
	// expected sink code, full scale 0xFFFF
	function [15:0] lvl(input [7:0] t, input [7:0] b, input h);
		lvl = 16'((64'hFFFF * b * ((h ? 64'h7F : 64'h0) + 2 * t))
			/ 64'h17B83);
	endfunction
	initial begin
		#500000;
		n_mismatch = n_mismatch + 1;
		close_out;
	end
	initial begin
		n_mismatch = 0;
		checked = 0;
		{nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb, chSel} = 57'h0;
		strbSel = 4'hF;
		blankingInputN = 1'h0;
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		@(posedge clk);
		rd(`STATUS_ADDR, 32'h0, `RESP_OKAY);
		for (i = 0; i < 24; i = i + 1)
			wr(`TRIM_BASE + 8'h04 * i, 32'h7F - 32'h5 * i, `RESP_OKAY);
		wr(`BRIGHT_BASE, 32'hFF, `RESP_OKAY);
		wr(`BRIGHT_BASE + 8'h04, 32'hFF, `RESP_OKAY);
		wr(`BRIGHT_BASE + 8'h08, 32'h180, `RESP_OKAY);
		wr(`RANGE_ADDR, 32'h5, `RESP_OKAY);
		wr(`TRIM_BASE + 8'h5C, 32'hFFFFFF8C, `RESP_OKAY);
		rd(`TRIM_BASE + 8'h5C, 32'h0C, `RESP_OKAY);
		rd(`BRIGHT_BASE + 8'h08, 32'h80, `RESP_OKAY);
		rd(`RANGE_ADDR, 32'h5, `RESP_OKAY);
		blankingInputN <= 1'h1;
		repeat (30) @(posedge clk);
		rd(`STATUS_ADDR, 32'h1, `RESP_OKAY);
		for (i = 0; i < 24; i = i + 1) begin
			chSel <= i[4:0];
			@(posedge clk);
			cmp("level", lvl(8'h7F - 8'h5 * i, i < 16 ? 8'hFF : 8'h80,
				i < 8 || i > 15), sinkCurrent);
		end
		cmp("full", 32'hFFFF, levelCodes[15:0]);
		cmp("lowg", 32'h74E9, levelCodes[143:128]);
		strbSel = 4'hE;
		wr(`TRIM_BASE, 32'h11, `RESP_OKAY);
		strbSel = 4'hF;
		rd(`TRIM_BASE, 32'h7F, `RESP_OKAY);
		blankingInputN <= 1'h0;
		repeat (4) @(posedge clk);
		cmp("sinks", 32'h0, sinkEnable);
		for (i = 0; i < 3; i = i + 1)
			rd(`COUNT_BASE + 8'h04 * i, 32'h0, `RESP_OKAY);
		rd(8'h80, 32'h0, `RESP_SLVERR);
		rd(8'h02, 32'h0, `RESP_SLVERR);
		wr(`STATUS_ADDR, 32'h1, `RESP_SLVERR);
		rd(`STATUS_ADDR, 32'h0, `RESP_OKAY);
		close_out;
	end
endmodule // led_current_scaling_bench
